// >>> logic/dda_defs.svh
// Constants for the dual-rank DDR3 access pair
`ifndef DDA_DEFS_SVH
`define DDA_DEFS_SVH
`define DDA_RANKS        2
`define DDA_BANKS        8
`define DDA_RB           16
`define DDA_BA_W         3
`define DDA_ROW_W        16
`define DDA_COL_W        10
`define DDA_IO_W         8
`define DDA_PAIR_W       16
`define DDA_WORD_W       64
`define DDA_WORDS        128
`define DDA_IDX_W        7
`define DDA_A10          10
`define DDA_RD_LAT       3'h2
`define DDA_WR_LAT       3'h1
`define DDA_GAP          3'h2
`define DDA_FIFO_DEPTH   8
`define DDA_CLK_MHZ      125
`define DDA_TREFI_NS     7800
`define DDA_TREFI_HOT_NS 3900
`define DDA_REF_CYC      ((`DDA_TREFI_NS * `DDA_CLK_MHZ) / 1000)
`define DDA_REF_HOT_CYC  ((`DDA_TREFI_HOT_NS * `DDA_CLK_MHZ) / 1000)
`define DDA_REF_W        10
`endif

// >>> logic/dda_pkg.sv
// Types shared by both ends of the DDR3 access pair
`default_nettype none
`include "dda_defs.svh"
package dda_pkg;
	// Command code is {row strobe, column strobe, write enable}
	typedef enum logic [2:0] {
		CMD_NOP = 3'h7,
		CMD_ACT = 3'h3,
		CMD_RD  = 3'h5,
		CMD_WR  = 3'h4,
		CMD_PRE = 3'h2,
		CMD_REF = 3'h1
	} dda_cmd_t;

	typedef enum logic [2:0] {
		C_IDLE = 3'h0,
		C_PRE  = 3'h1,
		C_ACT  = 3'h2,
		C_COL  = 3'h3,
		C_WDAT = 3'h4,
		C_RDAT = 3'h5,
		C_REFP = 3'h6,
		C_REFC = 3'h7
	} dda_cst_t;

	typedef struct packed {
		logic [`DDA_WORDS-1:0][`DDA_WORD_W-1:0] mem;
		logic [`DDA_RB-1:0]                     open;
		logic [`DDA_RB-1:0][`DDA_ROW_W-1:0]     row;
		logic                                   rd;
		logic                                   wr;
		logic [2:0]                             lat;
		logic [1:0]                             beat;
		logic [`DDA_IDX_W-1:0]                  idx;
		logic [2:0]                             scol;
		logic [`DDA_PAIR_W-1:0]                 dq;
		logic                                   dq_oe;
		logic                                   dqs_oe;
		logic                                   tdqs;
		logic                                   err;
	} dda_dev_t;

	typedef struct packed {
		dda_cst_t                               st;
		logic [2:0]                             gap;
		logic [`DDA_RANKS-1:0][`DDA_REF_W-1:0]  cnt;
		logic [`DDA_RANKS-1:0]                  due;
		logic                                   rrank;
		logic [`DDA_RB-1:0]                     open;
		logic [`DDA_RB-1:0][`DDA_ROW_W-1:0]     row;
		logic                                   wr;
		logic                                   rank;
		logic [`DDA_BA_W-1:0]                   ba;
		logic [`DDA_ROW_W-1:0]                  row_a;
		logic [`DDA_COL_W-1:0]                  col;
		logic [`DDA_WORD_W-1:0]                 wdata;
		logic [7:0]                             wmask;
		logic [1:0]                             beat;
		logic [`DDA_WORD_W-1:0]                 rdata;
		logic                                   push;
		logic                                   ready;
		logic [`DDA_RANKS-1:0]                  cs_n;
		dda_cmd_t                               cmd;
		logic [`DDA_ROW_W-1:0]                  addr;
		logic [`DDA_PAIR_W-1:0]                 dq;
		logic                                   dq_oe;
		logic [1:0]                             dm;
		logic                                   dqs_oe;
		logic                                   rst_pin;
		logic                                   ilv;
		logic                                   tdqs;
		logic                                   srt;
	} dda_ctl_t;

	// Byte position of a beat inside the core word, per burst order
	function automatic logic [2:0] dda_beat_pos(input logic [2:0] start,
		input logic [2:0] beat, input logic ilv);
		logic [1:0] low;
		low = start[1:0] + beat[1:0];
		if (ilv)
			return start ^ beat;
		return {start[2] ^ beat[2], low};
	endfunction
endpackage
`default_nettype wire

// >>> logic/dda_link_if.sv
// Pin-level link between controller and dual-rank memory
`timescale 1ns/10ps
`default_nettype none
`include "dda_defs.svh"
interface dda_link_if;
	logic                   reset_n;
	logic [`DDA_RANKS-1:0]  cs_n;
	logic                   ras_n;
	logic                   cas_n;
	logic                   we_n;
	logic [`DDA_BA_W-1:0]   ba;
	logic [`DDA_ROW_W-1:0]  addr;
	logic [1:0]             dm;
	logic                   ilv;
	logic                   tdqs_en;
	logic                   srt_en;
	logic [`DDA_PAIR_W-1:0] ctl_dq;
	logic                   ctl_dq_oe;
	logic                   ctl_dqs_t;
	logic                   ctl_dqs_c;
	logic                   ctl_dqs_oe;
	logic [`DDA_PAIR_W-1:0] dev_dq;
	logic                   dev_dq_oe;
	logic                   dev_dqs_t;
	logic                   dev_dqs_c;
	logic                   dev_dqs_oe;
	logic [`DDA_PAIR_W-1:0] dq;
	logic                   dqs_t;
	logic                   dqs_c;

	// Wire levels from the enables; an idle strobe reads as both low
	assign dq = dev_dq_oe ? dev_dq : (ctl_dq_oe ? ctl_dq : '0);
	assign dqs_t = dev_dqs_oe ? dev_dqs_t : (ctl_dqs_oe & ctl_dqs_t);
	assign dqs_c = dev_dqs_oe ? dev_dqs_c : (ctl_dqs_oe & ctl_dqs_c);

	modport ctl (output reset_n, cs_n, ras_n, cas_n, we_n, ba, addr, dm,
		ilv, tdqs_en, srt_en, ctl_dq, ctl_dq_oe, ctl_dqs_t, ctl_dqs_c,
		ctl_dqs_oe, input dq, dqs_t, dqs_c);
	modport dev (input reset_n, cs_n, ras_n, cas_n, we_n, ba, addr, dm,
		ilv, tdqs_en, srt_en, dq, dqs_t, dqs_c, output dev_dq, dev_dq_oe,
		dev_dqs_t, dev_dqs_c, dev_dqs_oe);
endinterface
`default_nettype wire

// >>> logic/dda_mem_dev.sv
// Memory end: two ranks of eight banks behind one pin link
`timescale 1ns/10ps
`default_nettype none
`include "dda_defs.svh"
module dda_mem_dev (
	input  wire logic clk_in,
	dda_link_if.dev   link,
	output logic      err_out,
	output logic      tdqs_term_out
);
	dda_pkg::dda_dev_t q;
	dda_pkg::dda_dev_t d;
	dda_pkg::dda_cmd_t cmd;

	assign cmd = dda_pkg::dda_cmd_t'({link.ras_n, link.cas_n, link.we_n});

	// Next state: burst progress first, then a new command may override
	always_comb begin
		logic [3:0] rb;
		logic [2:0] pos;
		rb = '0;
		pos = '0;
		d = q;
		d.dq = '0;
		d.dq_oe = 1'b0;
		d.dqs_oe = 1'b0;
		d.err = 1'b0;
		d.tdqs = link.tdqs_en;
		// Read beats go out as a pair per clock, strobe with them
		if (q.rd) begin
			if (q.lat != 3'h0) begin
				d.lat = q.lat - 3'h1;
			end else begin
				for (int k = 0; k < 2; k++) begin
					pos = dda_pkg::dda_beat_pos(q.scol, {q.beat, k[0]},
						link.ilv);
					d.dq[k*8 +: 8] = q.mem[q.idx][pos*8 +: 8];
				end
				d.dq_oe = 1'b1;
				d.dqs_oe = 1'b1;
				d.beat = q.beat + 2'h1;
				if (q.beat == 2'h3)
					d.rd = 1'b0;
			end
		end
		// Write beats are taken only in the centred strobe phase
		if (q.wr && !link.dqs_t && link.dqs_c) begin
			for (int k = 0; k < 2; k++) begin
				pos = dda_pkg::dda_beat_pos(q.scol, {q.beat, k[0]}, link.ilv);
				if (!link.dm[k] || q.tdqs)
					d.mem[q.idx][pos*8 +: 8] = link.dq[k*8 +: 8];
			end
			d.beat = q.beat + 2'h1;
			if (q.beat == 2'h3)
				d.wr = 1'b0;
		end
		// Each rank decodes on its own select; the higher rank wins a tie
		for (int r = 0; r < `DDA_RANKS; r++) begin
			rb = {r[0], link.ba};
			if (!link.cs_n[r]) begin
				case (cmd)
				dda_pkg::CMD_ACT: begin
					d.open[rb] = 1'b1;
					d.row[rb] = link.addr;
				end
				dda_pkg::CMD_PRE: begin
					for (int b = 0; b < `DDA_BANKS; b++) begin
						if (link.addr[`DDA_A10] || link.ba == b[2:0])
							d.open[{r[0], b[2:0]}] = 1'b0;
					end
				end
				dda_pkg::CMD_RD,
				dda_pkg::CMD_WR: begin
					d.rd = (cmd == dda_pkg::CMD_RD);
					d.wr = (cmd == dda_pkg::CMD_WR);
					d.lat = `DDA_RD_LAT;
					d.beat = 2'h0;
					d.idx = {r[0], link.ba, q.row[rb][0],
						link.addr[4:3]};
					d.scol = link.addr[2:0];
					d.err = !q.open[rb];
				end
				default: begin
					// Refresh needs no action in this model
				end
				endcase
			end
		end
	end

	// Whole state in one register; the reset pin clears it at once
	always_ff @(posedge clk_in or negedge link.reset_n) begin
		if (!link.reset_n)
			q <= '0;
		else
			q <= d;
	end

	// Pin drive straight from the state register
	assign link.dev_dq = q.dq;
	assign link.dev_dq_oe = q.dq_oe;
	assign link.dev_dqs_t = q.dqs_oe;
	assign link.dev_dqs_c = 1'b0;
	assign link.dev_dqs_oe = q.dqs_oe;
	assign err_out = q.err;
	assign tdqs_term_out = q.tdqs;
endmodule
`default_nettype wire

// >>> logic/dda_ctl_host.sv
// Controller end with its read-return FIFO
`timescale 1ns/10ps
`default_nettype none
`include "dda_defs.svh"
module dda_fifo #(
	parameter int W = 64,
	parameter int D = 8
) (
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	input  wire logic [W-1:0] in_data_in,
	output logic              out_valid_out,
	input  wire logic         out_ready_in,
	output logic [W-1:0]      out_data_out
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
		logic [W-1:0]        head;
		logic                vld;
	} dda_fifo_t;
	dda_fifo_t q;
	dda_fifo_t d;
	logic      push;
	logic      pop;

	assign in_ready_out = (q.cnt != (AW+1)'(D));
	// Flag and head word registered so the outputs leave flip-flops
	assign out_valid_out = q.vld;
	assign out_data_out = q.head;
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	// Pointers wrap at the depth, so it need not be a power of two
	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wp] = in_data_in;
			d.wp = (q.wp == AW'(D-1)) ? '0 : q.wp + 1'b1;
		end
		if (pop)
			d.rp = (q.rp == AW'(D-1)) ? '0 : q.rp + 1'b1;
		d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		d.vld = (d.cnt != '0);
		d.head = d.mem[d.rp];
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			q <= '0;
		else
			q <= d;
	end
endmodule

module dda_ctl_host (
	input  wire logic                   clk_in,
	input  wire logic                   rst_n_in,
	input  wire logic                   req_valid_in,
	input  wire logic                   req_write_in,
	input  wire logic                   req_rank_in,
	input  wire logic [`DDA_BA_W-1:0]   req_bank_in,
	input  wire logic [`DDA_ROW_W-1:0]  req_row_in,
	input  wire logic [`DDA_COL_W-1:0]  req_col_in,
	input  wire logic [`DDA_WORD_W-1:0] req_wdata_in,
	input  wire logic [7:0]             req_wmask_in,
	output logic                        req_ready_out,
	output logic                        rd_valid_out,
	output logic [`DDA_WORD_W-1:0]      rd_data_out,
	input  wire logic                   rd_ready_in,
	input  wire logic                   hot_in,
	input  wire logic                   ilv_in,
	input  wire logic                   tdqs_en_in,
	dda_link_if.ctl                     link
);
	dda_pkg::dda_ctl_t q;
	dda_pkg::dda_ctl_t d;
	logic              fifo_rdy;

	// Next state: one command per step, spaced by the gap counter
	always_comb begin
		logic [3:0] rb;
		logic [3:0] rbn;
		logic [2:0] pos;
		rb = {q.rank, q.ba};
		rbn = {req_rank_in, req_bank_in};
		pos = '0;
		d = q;
		d.cs_n = 2'h3;
		d.cmd = dda_pkg::CMD_NOP;
		d.dq_oe = 1'b0;
		d.dqs_oe = 1'b0;
		d.dm = 2'h0;
		d.push = 1'b0;
		d.rst_pin = 1'b1;
		d.ilv = ilv_in;
		d.tdqs = tdqs_en_in;
		d.srt = hot_in;
		if (q.gap != 3'h0)
			d.gap = q.gap - 3'h1;
		unique case (q.st)
		dda_pkg::C_IDLE: begin
			if (q.due != '0) begin
				d.rrank = !q.due[0];
				d.st = dda_pkg::C_REFP;
			end else if (req_valid_in && q.ready) begin
				d.wr = req_write_in;
				d.rank = req_rank_in;
				d.ba = req_bank_in;
				d.row_a = req_row_in;
				d.col = req_col_in;
				d.wdata = req_wdata_in;
				d.wmask = req_wmask_in;
				// Hit goes straight to the column step, miss reopens
				if (!q.open[rbn])
					d.st = dda_pkg::C_ACT;
				else if (q.row[rbn] == req_row_in)
					d.st = dda_pkg::C_COL;
				else
					d.st = dda_pkg::C_PRE;
			end
		end
		dda_pkg::C_PRE: if (q.gap == 3'h0) begin
			d.cs_n = ~(2'h1 << q.rank);
			d.cmd = dda_pkg::CMD_PRE;
			d.ba = q.ba;
			d.addr = '0;
			d.open[rb] = 1'b0;
			d.gap = `DDA_GAP;
			d.st = dda_pkg::C_ACT;
		end
		dda_pkg::C_ACT: if (q.gap == 3'h0) begin
			d.cs_n = ~(2'h1 << q.rank);
			d.cmd = dda_pkg::CMD_ACT;
			d.addr = q.row_a;
			d.open[rb] = 1'b1;
			d.row[rb] = q.row_a;
			d.gap = `DDA_GAP;
			d.st = dda_pkg::C_COL;
		end
		dda_pkg::C_COL: if (q.gap == 3'h0) begin
			d.cs_n = ~(2'h1 << q.rank);
			d.cmd = q.wr ? dda_pkg::CMD_WR : dda_pkg::CMD_RD;
			d.addr = {6'h00, q.col};
			d.beat = 2'h0;
			d.gap = q.wr ? `DDA_WR_LAT : 3'h0;
			d.st = q.wr ? dda_pkg::C_WDAT : dda_pkg::C_RDAT;
		end
		dda_pkg::C_WDAT: if (q.gap == 3'h0) begin
			for (int k = 0; k < 2; k++) begin
				pos = dda_pkg::dda_beat_pos(q.col[2:0], {q.beat, k[0]}, q.ilv);
				d.dq[k*8 +: 8] = q.wdata[pos*8 +: 8];
				d.dm[k] = q.wmask[pos];
			end
			d.dq_oe = 1'b1;
			d.dqs_oe = 1'b1;
			d.beat = q.beat + 2'h1;
			if (q.beat == 2'h3) begin
				d.gap = `DDA_GAP;
				d.st = dda_pkg::C_IDLE;
			end
		end
		dda_pkg::C_RDAT: if (link.dqs_t && !link.dqs_c) begin
			// Only one read is ever in flight, so FIFO room is assured
			for (int k = 0; k < 2; k++) begin
				pos = dda_pkg::dda_beat_pos(q.col[2:0], {q.beat, k[0]}, q.ilv);
				d.rdata[pos*8 +: 8] = link.dq[k*8 +: 8];
			end
			d.beat = q.beat + 2'h1;
			if (q.beat == 2'h3) begin
				d.push = 1'b1;
				d.st = dda_pkg::C_IDLE;
			end
		end
		dda_pkg::C_REFP: if (q.gap == 3'h0) begin
			d.cs_n = ~(2'h1 << q.rrank);
			d.cmd = dda_pkg::CMD_PRE;
			d.addr = '0;
			d.addr[`DDA_A10] = 1'b1; // All banks of the rank
			for (int b = 0; b < `DDA_BANKS; b++)
				d.open[{q.rrank, b[2:0]}] = 1'b0;
			d.gap = `DDA_GAP;
			d.st = dda_pkg::C_REFC;
		end
		dda_pkg::C_REFC: if (q.gap == 3'h0) begin
			d.cs_n = ~(2'h1 << q.rrank);
			d.cmd = dda_pkg::CMD_REF;
			d.due[q.rrank] = 1'b0;
			d.gap = `DDA_GAP;
			d.st = dda_pkg::C_IDLE;
		end
		endcase
		// Free-running interval per rank keeps the average rate exact;
		// placed after the clear so a new due is never lost
		for (int r = 0; r < `DDA_RANKS; r++) begin
			if (q.cnt[r] == '0) begin
				d.due[r] = 1'b1;
				d.cnt[r] = hot_in ? `DDA_REF_W'(`DDA_REF_HOT_CYC) :
					`DDA_REF_W'(`DDA_REF_CYC);
			end else begin
				d.cnt[r] = q.cnt[r] - 1'b1;
			end
		end
		d.ready = (d.st == dda_pkg::C_IDLE) && (d.due == '0) &&
			fifo_rdy && !d.push && !q.push;
	end

	// Reset holds the memory reset pin low and the selects idle
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= '0;
			q.cs_n <= 2'h3;
			q.cmd <= dda_pkg::CMD_NOP;
		end else begin
			q <= d;
		end
	end

	dda_fifo #(
		.W (`DDA_WORD_W),
		.D (`DDA_FIFO_DEPTH)
	) u_rfifo (
		.clk_in        (clk_in),
		.rst_n_in      (rst_n_in),
		.in_valid_in   (q.push),
		.in_ready_out  (fifo_rdy),
		.in_data_in    (q.rdata),
		.out_valid_out (rd_valid_out),
		.out_ready_in  (rd_ready_in),
		.out_data_out  (rd_data_out)
	);

	// Pin drive from the state register; write strobe in centred phase
	assign link.reset_n = q.rst_pin;
	assign link.cs_n = q.cs_n;
	assign link.ras_n = q.cmd[2];
	assign link.cas_n = q.cmd[1];
	assign link.we_n = q.cmd[0];
	assign link.ba = q.ba;
	assign link.addr = q.addr;
	assign link.dm = q.dm;
	assign link.ilv = q.ilv;
	assign link.tdqs_en = q.tdqs;
	assign link.srt_en = q.srt;
	assign link.ctl_dq = q.dq;
	assign link.ctl_dq_oe = q.dq_oe;
	assign link.ctl_dqs_t = 1'b0;
	assign link.ctl_dqs_c = q.dqs_oe;
	assign link.ctl_dqs_oe = q.dqs_oe;
	assign req_ready_out = q.ready;
endmodule
`default_nettype wire

// >>> sim/dda_link_sva.sv
// Link protocol checker between the controller end and the memory end
`timescale 1ns/10ps
`default_nettype none
`include "dda_defs.svh"
module dda_link_sva (
	input wire logic                  clk_in,
	input wire logic                  rst_n_in,
	input wire logic [`DDA_RANKS-1:0] cs_n,
	input wire logic                  ras_n,
	input wire logic                  cas_n,
	input wire logic                  we_n,
	input wire logic [`DDA_BA_W-1:0]  ba,
	input wire logic [`DDA_ROW_W-1:0] addr,
	input wire logic                  srt_en,
	input wire logic                  ctl_dq_oe,
	input wire logic                  ctl_dqs_oe,
	input wire logic                  dev_dq_oe,
	input wire logic                  dev_dqs_oe,
	input wire logic                  dqs_t,
	input wire logic                  dqs_c
);
	// Refresh interval ceilings with slack for a transfer in flight
	localparam int COLD_MAX = 1015;
	localparam int HOT_MAX = 527;
	logic [2:0]         cmd;
	logic               live;
	logic               rk;
	logic [3:0]         idx;
	logic               is_act;
	logic               is_pre;
	logic               is_ref;
	logic               is_rd;
	logic               is_wr;
	logic [`DDA_RB-1:0] open_q;
	logic [1:0][10:0]   age_q;
	logic [1:0]         hot_q;

	// Command decode from strobes and selects
	assign cmd = {ras_n, cas_n, we_n};
	assign live = (cs_n != 2'h3) && (cmd != dda_pkg::CMD_NOP);
	assign rk = cs_n[0];
	assign idx = {rk, ba};
	assign is_act = live && (cmd == dda_pkg::CMD_ACT);
	assign is_pre = live && (cmd == dda_pkg::CMD_PRE);
	assign is_ref = live && (cmd == dda_pkg::CMD_REF);
	assign is_rd = live && (cmd == dda_pkg::CMD_RD);
	assign is_wr = live && (cmd == dda_pkg::CMD_WR);

	// Shadow of open banks and refresh age per rank
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			open_q <= '0;
			age_q <= '0;
			hot_q <= '0;
		end else begin
			if (is_act)
				open_q[idx] <= 1'b1;
			if (is_pre && addr[`DDA_A10])
				open_q[rk*8 +: 8] <= 8'h00;
			else if (is_pre)
				open_q[idx] <= 1'b0;
			for (int r = 0; r < 2; r++) begin
				if (is_ref && rk == r[0]) begin
					age_q[r] <= '0;
					hot_q[r] <= srt_en;
				end else if (age_q[r] != 11'h7ff)
					age_q[r] <= age_q[r] + 11'h1;
			end
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	// Read beats come with the memory's strobe, write beats with ours
	sequence rd_burst;
		(dev_dq_oe && dev_dqs_oe && dqs_t && !dqs_c) [*4];
	endsequence
	sequence wr_burst;
		(ctl_dq_oe && ctl_dqs_oe && !dqs_t && dqs_c) [*4];
	endsequence

	chk_one_rank: assert property (live |-> cs_n != 2'h0)
		else $error("command selects both ranks");
	chk_rd_beats: assert property (is_rd |-> ##4 rd_burst)
		else $error("read burst not four edge-aligned cycles");
	chk_wr_beats: assert property (is_wr |-> ##2 wr_burst)
		else $error("write burst not four centred cycles");
	chk_col_open: assert property (is_rd || is_wr |-> open_q[idx])
		else $error("column command to closed bank");
	chk_act_closed: assert property (is_act |-> !open_q[idx])
		else $error("activate to an open bank");
	chk_ref_closed: assert property (
		is_ref |-> open_q[rk*8 +: 8] == 8'h00)
		else $error("refresh with a bank open");
	chk_cmd_gap: assert property (live |=> !live)
		else $error("commands back to back");
	chk_dq_owner: assert property (!(dev_dq_oe && ctl_dq_oe))
		else $error("both ends drive data");
	chk_ref_rate: assert property (
		age_q[0] <= (hot_q[0] ? HOT_MAX : COLD_MAX) &&
		age_q[1] <= (hot_q[1] ? HOT_MAX : COLD_MAX))
		else $error("refresh interval exceeded");
endmodule
`default_nettype wire

// >>> sim/dual_rank_ddr3_access_bench.sv
// Self-checking bench for the controller and memory pair
`timescale 1ns/10ps
`default_nettype none
`include "dda_defs.svh"
module dual_rank_ddr3_access_bench;
	localparam int LIMIT = 40000;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        rv = 1'b0;
	logic        rw = 1'b0;
	logic        rr = 1'b0;
	logic [2:0]  rb = 3'h0;
	logic [15:0] rrow = 16'h0;
	logic [9:0]  rcol = 10'h0;
	logic [63:0] rwd = 64'h0;
	logic [7:0]  rwm = 8'h0;
	logic        rdy = 1'b0;
	logic        hot = 1'b0;
	logic        ilv = 1'b0;
	logic        tdq = 1'b0;
	logic        req_ready;
	logic        rd_valid;
	logic [63:0] rd_data;
	logic        err;
	logic        term;
	logic [63:0] mem_m [128];
	logic [63:0] exp_q [$];
	bit          drain = 1'b0;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          cyc = 0;

	dda_link_if u_dda_link_if ();
	dda_ctl_host u_dda_ctl_host (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.req_valid_in(rv), .req_write_in(rw), .req_rank_in(rr),
		.req_bank_in(rb), .req_row_in(rrow), .req_col_in(rcol),
		.req_wdata_in(rwd), .req_wmask_in(rwm), .req_ready_out(req_ready),
		.rd_valid_out(rd_valid), .rd_data_out(rd_data), .rd_ready_in(rdy),
		.hot_in(hot), .ilv_in(ilv), .tdqs_en_in(tdq),
		.link(u_dda_link_if));
	dda_mem_dev u_dda_mem_dev (.clk_in(clk_in), .link(u_dda_link_if),
		.err_out(err), .tdqs_term_out(term));
	dda_link_sva u_dda_link_sva (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.cs_n(u_dda_link_if.cs_n), .ras_n(u_dda_link_if.ras_n),
		.cas_n(u_dda_link_if.cas_n), .we_n(u_dda_link_if.we_n),
		.ba(u_dda_link_if.ba), .addr(u_dda_link_if.addr),
		.srt_en(u_dda_link_if.srt_en),
		.ctl_dq_oe(u_dda_link_if.ctl_dq_oe),
		.ctl_dqs_oe(u_dda_link_if.ctl_dqs_oe),
		.dev_dq_oe(u_dda_link_if.dev_dq_oe),
		.dev_dqs_oe(u_dda_link_if.dev_dqs_oe),
		.dqs_t(u_dda_link_if.dqs_t), .dqs_c(u_dda_link_if.dqs_c));

	always #4 clk_in = ~clk_in;

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Hang guard: a stuck handshake ends the run as a failure
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == LIMIT) begin
			error_cnt++;
			complete_run();
		end
	end

	// Popped words against the model; memory end must never flag a fault
	always @(posedge clk_in) begin
		if (rst_n_in && rd_valid === 1'b1 && rdy)
			check(rd_data, exp_q.size() != 0 ? exp_q.pop_front() : 64'hx);
		if (rst_n_in)
			check({63'h0, err}, 64'h0);
	end

	// Consumer stalls at random so the FIFO sees back pressure
	always @(negedge clk_in)
		rdy <= drain && ($urandom % 4 != 0);

	// One user request on a random address within a small alias set
	task automatic req(input logic w);
		int n;
		logic [6:0] ix;
		n = 0;
		// A fresh cycle keeps valid low between two requests
		@(negedge clk_in);
		rw = w;
		rr = 1'($urandom);
		rb = 3'($urandom % 2);
		rrow = 16'($urandom % 4);
		rcol = 10'($urandom);
		rwd = {$urandom, $urandom};
		rwm = ($urandom % 2) ? 8'h00 : 8'($urandom);
		rv = 1'b1;
		ix = {rr, rb, rrow[0], rcol[4:3]};
		while (req_ready !== 1'b1 && n < 3000) begin
			@(negedge clk_in);
			n++;
		end
		@(negedge clk_in);
		rv = 1'b0;
		if (n >= 3000)
			error_cnt++;
		// Masking is off while the strobe pins terminate
		for (int i = 0; i < 8; i++) begin
			if (w && (!rwm[i] || tdq))
				mem_m[ix][8*i +: 8] = rwd[8*i +: 8];
		end
		if (!w)
			exp_q.push_back(mem_m[ix]);
	endtask

	task automatic settle();
		int n;
		n = 0;
		while ((exp_q.size() != 0 || req_ready !== 1'b1) && n < 3000) begin
			@(negedge clk_in);
			n++;
		end
		if (n >= 3000)
			error_cnt++;
	endtask

	// Reset mid-cycle; selects must idle before any clock edge
	task automatic do_reset(input int p);
		@(negedge clk_in);
		rst_n_in = 1'b0;
		ilv = p[0];
		tdq = p[1];
		hot = (p == 2);
		#2;
		check({u_dda_link_if.reset_n, u_dda_link_if.cs_n}, 64'h3);
		check({63'h0, rd_valid}, 64'h0);
		exp_q.delete();
		foreach (mem_m[i])
			mem_m[i] = 64'h0;
		repeat (5) @(negedge clk_in);
		rst_n_in = 1'b1;
	endtask

	initial begin
		void'($urandom(32'hd94281d1));
		for (int p = 0; p < 4; p++) begin
			do_reset(p);
			repeat (3) @(negedge clk_in);
			check({63'h0, term}, {63'h0, tdq});
			check({63'h0, u_dda_link_if.srt_en}, {63'h0, hot});
			check({63'h0, u_dda_link_if.ilv}, {63'h0, ilv});
			drain = 1'b1;
			// Mixed traffic: hits, misses, both ranks, every start byte
			repeat (25) begin
				req(1'b1);
				req(1'b0);
			end
			settle();
			// Fill the read FIFO with the consumer stalled
			drain = 1'b0;
			repeat (8) req(1'b0);
			repeat (40) @(negedge clk_in);
			check({62'h0, req_ready, rd_valid}, 64'h1);
			drain = 1'b1;
			req(1'b0);
			settle();
			// Idle long enough for at least one full refresh interval
			repeat (1100) @(negedge clk_in);
			check({63'h0, err}, 64'h0);
		end
		complete_run();
	end
endmodule
`default_nettype wire
